// ==== verilog/strap_decode_clock_select.sv ====
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "strap_decode_consts.svh"

module strap_decode_clock_select #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    input  wire logic          CLK,
    input  wire logic          RSTN,
    // pins from the host
    input  wire logic          SYSTEM_RESET_N,
    input  wire logic          REFERENCE_CLOCK_IN,
    input  wire logic          CLOCK_SOURCE_STRAP,
    input  wire logic          DIVIDER_STRAP,
    input  wire logic          SCRAMBLER_SEED_RESET_OFF,
    input  wire logic          TEST_PIN,
    // register port
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [DW-1:0] WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [DW-1:0] RDATA,
    // decoded outputs
    output logic               INT,
    output logic               LOGIC_RESET_N,
    output logic      [1:0]    PLL_SOURCE,
    output logic      [3:0]    PRE_DIVIDE,
    output logic      [3:0]    POST_DIVIDE,
    output logic               SEED_RESET_ENABLE,
    output logic               TEST_MODE
);

    localparam int NI = `SDC_IRQ_WIDTH;

    // each decode serves twice: for the captured straps and for the live preview
    // pll source from the clock-source strap and the reference level
    function automatic strap_decode_pkg::pll_source_t decode_source(
        input logic source_strap,
        input logic ref_level
    );
        strap_decode_pkg::pll_source_t src;
        if (!source_strap) begin
            src = strap_decode_pkg::SRC_REFERENCE;
        end else if (!ref_level) begin
            src = strap_decode_pkg::SRC_RECEIVER;
        end else begin
            src = strap_decode_pkg::SRC_PIXEL;
        end
        return src;
    endfunction : decode_source

    // second divider stage; zero when the receiver path is not in use
    function automatic logic [3:0] decode_post(
        input logic source_strap,
        input logic ref_level,
        input logic div_strap
    );
        logic [3:0] post;
        post = `SDC_NO_DIVIDE;
        if (source_strap && !ref_level) begin
            post = div_strap ? `SDC_POST_DIVIDE_HI : `SDC_POST_DIVIDE_LO;
        end
        return post;
    endfunction : decode_post

    // first divider stage, present only on the receiver path
    function automatic logic [3:0] decode_pre(
        input logic source_strap,
        input logic ref_level
    );
        logic [3:0] pre;
        pre = `SDC_NO_DIVIDE;
        if (source_strap && !ref_level) begin
            pre = `SDC_PRE_DIVIDE;
        end
        return pre;
    endfunction : decode_pre

    // ------------------------------------------------------------------
    // pin synchronisers; the reference pin is only looked at as a level
    // ------------------------------------------------------------------
    wire        sys_run_n;
    wire [3:0]  strap_live;
    wire        test_live;
    wire        seed_off_live;

    // a one-cycle glitch on any pin never gets past the agreement of two stages
    // system reset pin: starts held so nothing runs before it is seen high
    pin_sync #(
        .WIDTH     (1),
        .RST_VALUE (64'h0)
    ) u_sync_reset (
        .clk   (CLK),
        .rst_n (RSTN),
        .pin   (SYSTEM_RESET_N),
        .level (sys_run_n)
    );

    // pins: {seed-off, test, spare, divider, source, reference}
    pin_sync #(
        .WIDTH     (6),
        .RST_VALUE (64'h0)
    ) u_sync_straps (
        .clk   (CLK),
        .rst_n (RSTN),
        .pin   ({SCRAMBLER_SEED_RESET_OFF, TEST_PIN, 1'b0,
                 DIVIDER_STRAP, CLOCK_SOURCE_STRAP, REFERENCE_CLOCK_IN}),
        .level ({seed_off_live, test_live, strap_live})
    );

    wire ref_live     = strap_live[0];
    wire source_live  = strap_live[1];
    wire divider_live = strap_live[2];

    // either reset holds everything after the pin synchronisers (those take RSTN only), status and mask included, so software
    // always meets a clean register set after the pin has been pulsed
    // combined internal reset
    wire run = RSTN && sys_run_n;

    // ------------------------------------------------------------------
    // reset sequence: held, one capture cycle, then run
    // ------------------------------------------------------------------
    strap_decode_pkg::run_state_t state;
    strap_decode_pkg::run_state_t next_state;

    // the capture cycle lets the synchronised straps settle for one more edge
    // next state
    always_comb begin
        next_state = state;
        case (state)
            strap_decode_pkg::ST_HELD:    next_state = strap_decode_pkg::ST_CAPTURE;
            strap_decode_pkg::ST_CAPTURE: next_state = strap_decode_pkg::ST_RUN;
            strap_decode_pkg::ST_RUN:     next_state = strap_decode_pkg::ST_RUN;
            default:                      next_state = strap_decode_pkg::ST_HELD;
        endcase
    end

    // held while the pin is low
    always_ff @(posedge CLK) begin
        if (!run) begin
            state <= strap_decode_pkg::ST_HELD;
        end else begin
            state <= next_state;
        end
    end

    wire capturing = (state == strap_decode_pkg::ST_CAPTURE);
    wire running   = (state == strap_decode_pkg::ST_RUN);

    // ------------------------------------------------------------------
    // captured straps; taken by a clocked process after release, never by reset
    // ------------------------------------------------------------------
    logic ref_cap;
    logic source_cap;
    logic divider_cap;

    always_ff @(posedge CLK) begin
        if (!run) begin
            ref_cap     <= 1'b0;
            source_cap  <= 1'b0;
            divider_cap <= 1'b0;
        end else if (capturing) begin
            ref_cap     <= ref_live;
            source_cap  <= source_live;
            divider_cap <= divider_live;
        end
    end

    // decodes of captured and live straps; the live one is only for software preview
    wire strap_decode_pkg::pll_source_t src_cap  = decode_source(source_cap, ref_cap);
    wire strap_decode_pkg::pll_source_t src_live = decode_source(source_live, ref_live);
    wire [3:0] post_cap  = decode_post(source_cap, ref_cap, divider_cap);
    wire [3:0] post_live = decode_post(source_live, ref_live, divider_live);
    wire [3:0] pre_cap   = decode_pre(source_cap, ref_cap);
    wire [3:0] pre_live  = decode_pre(source_live, ref_live);

    // only the clock straps count here; test and seed-off are live on purpose
    // the host moved a strap after capture: flagged, never acted upon
    wire strap_moved = running &&
                       ({divider_live, source_live, ref_live} !=
                        {divider_cap, source_cap, ref_cap});

    // ------------------------------------------------------------------
    // decoded outputs, registered
    // ------------------------------------------------------------------
    // test and seed-off follow the live pins; only the clock choice is frozen
    // outputs stay at the reference path and normal mode while held
    always_ff @(posedge CLK) begin
        if (!run) begin
            LOGIC_RESET_N     <= 1'b0;
            PLL_SOURCE        <= strap_decode_pkg::SRC_REFERENCE;
            PRE_DIVIDE        <= `SDC_NO_DIVIDE;
            POST_DIVIDE       <= `SDC_NO_DIVIDE;
            SEED_RESET_ENABLE <= 1'b0;
            TEST_MODE         <= 1'b0;
        end else begin
            LOGIC_RESET_N     <= running;
            PLL_SOURCE        <= src_cap;
            PRE_DIVIDE        <= pre_cap;
            POST_DIVIDE       <= post_cap;
            SEED_RESET_ENABLE <= running && !seed_off_live;
            TEST_MODE         <= running && test_live;
        end
    end

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    // strobes only qualify the writes and the read below; the decode is address only
    wire hit_status  = (ADDR == `SDC_OFS_STATUS);
    wire hit_mask    = (ADDR == `SDC_OFS_MASK);
    wire hit_control = (ADDR == `SDC_OFS_CONTROL);
    wire hit_capture = (ADDR == `SDC_OFS_CAPTURE);
    wire hit_pins    = (ADDR == `SDC_OFS_PINS);

    wire wr_status  = WR && hit_status;
    wire wr_mask    = WR && hit_mask;
    wire wr_control = WR && hit_control;

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    logic            moved_d;
    logic            test_d;
    logic [NI-1:0]   status;
    logic [NI-1:0]   mask;
    wire  [NI-1:0]   event_set;
    wire  [NI-1:0]   next_status;
    wire  [NI-1:0]   next_mask;

    // one-cycle events: release, first mismatch, test entry, software request
    assign event_set[`SDC_IRQ_RELEASED]    = capturing;
    assign event_set[`SDC_IRQ_STRAP_MOVED] = strap_moved && !moved_d;
    assign event_set[`SDC_IRQ_TEST_ENTER]  = running && test_live && !test_d;
    assign event_set[`SDC_IRQ_SOFT]        = wr_control && WDATA[`SDC_CTL_SOFT_IRQ];

    // write-one-to-clear; a set in the same cycle wins over the clear
    assign next_status = (status & ~(wr_status ? WDATA[NI-1:0] : {NI{1'b0}})) | event_set;

    // mask as it stands after this edge, so a mask write reaches INT at once
    assign next_mask = wr_mask ? WDATA[NI-1:0] : mask;

    // history resets low, matching the idle pins, so run never opens on a false edge
    // edge history for the event detectors
    always_ff @(posedge CLK) begin
        if (!run) begin
            moved_d <= 1'b0;
            test_d  <= 1'b0;
        end else begin
            moved_d <= strap_moved;
            test_d  <= running && test_live;
        end
    end

    // sticky status and mask
    always_ff @(posedge CLK) begin
        if (!run) begin
            status <= `SDC_RST_STATUS;
            mask   <= `SDC_RST_MASK;
        end else begin
            status <= next_status;
            mask   <= next_mask;
        end
    end

    // registered from next_status and next_mask: INT changes on the same edge as status and mask
    // level interrupt
    always_ff @(posedge CLK) begin
        if (!run) begin
            INT <= 1'b0;
        end else begin
            INT <= |(next_status & next_mask);
        end
    end

    // ------------------------------------------------------------------
    // read path: data stand one cycle after the strobe, only then
    // ------------------------------------------------------------------
    logic [DW-1:0] capture_word;
    logic [DW-1:0] pins_word;
    wire  [DW-1:0] read_word;

    // capture register: the decode in force
    always_comb begin
        capture_word = '0;
        capture_word[`SDC_FLD_SOURCE_HI:`SDC_FLD_SOURCE_LO] = src_cap;
        capture_word[`SDC_FLD_PRE_HI:`SDC_FLD_PRE_LO]       = pre_cap;
        capture_word[`SDC_FLD_POST_HI:`SDC_FLD_POST_LO]     = post_cap;
        capture_word[`SDC_FLD_STRAPS_HI:`SDC_FLD_STRAPS_LO] =
            {1'b0, divider_cap, source_cap, ref_cap};
        capture_word[`SDC_FLD_TEST]     = TEST_MODE;
        capture_word[`SDC_FLD_SEED_OFF] = !SEED_RESET_ENABLE;
    end

    // pins register: what the straps would decode to now
    always_comb begin
        pins_word = '0;
        pins_word[`SDC_FLD_SOURCE_HI:`SDC_FLD_SOURCE_LO] = src_live;
        pins_word[`SDC_FLD_PRE_HI:`SDC_FLD_PRE_LO]       = pre_live;
        pins_word[`SDC_FLD_POST_HI:`SDC_FLD_POST_LO]     = post_live;
        pins_word[`SDC_FLD_STRAPS_HI:`SDC_FLD_STRAPS_LO] = strap_live;
        pins_word[`SDC_FLD_TEST]     = test_live;
        pins_word[`SDC_FLD_SEED_OFF] = seed_off_live;
    end

    // unmapped addresses read zero
    assign read_word = hit_status  ? {{(DW-NI){1'b0}}, status} :
                       hit_mask    ? {{(DW-NI){1'b0}}, mask}   :
                       hit_capture ? capture_word              :
                       hit_pins    ? pins_word                 :
                       '0;

    // data stay zero outside the read cycle so a late sample never sees stale data
    // control reads zero: its only bit is a self-clearing request
    always_ff @(posedge CLK) begin
        if (!run) begin
            RDATA <= `SDC_RST_RDATA;
        end else if (RD && !hit_control) begin
            RDATA <= read_word;
        end else begin
            RDATA <= `SDC_RST_RDATA;
        end
    end

endmodule : strap_decode_clock_select

`default_nettype wire

// ==== verilog/strap_decode_consts.svh ====
`ifndef STRAP_DECODE_CONSTS_SVH
`define STRAP_DECODE_CONSTS_SVH

// register byte offsets
`define SDC_OFS_STATUS      8'h00
`define SDC_OFS_MASK        8'h04
`define SDC_OFS_CONTROL     8'h08
`define SDC_OFS_CAPTURE     8'h0C
`define SDC_OFS_PINS        8'h10

// interrupt status and mask bit positions
`define SDC_IRQ_RELEASED    0
`define SDC_IRQ_STRAP_MOVED 1
`define SDC_IRQ_TEST_ENTER  2
`define SDC_IRQ_SOFT        3
`define SDC_IRQ_WIDTH       4

// control register bit positions
`define SDC_CTL_SOFT_IRQ    0

// capture and pins register field positions
`define SDC_FLD_SOURCE_LO   0
`define SDC_FLD_SOURCE_HI   1
`define SDC_FLD_PRE_LO      4
`define SDC_FLD_PRE_HI      7
`define SDC_FLD_POST_LO     8
`define SDC_FLD_POST_HI     11
`define SDC_FLD_STRAPS_LO   16
`define SDC_FLD_STRAPS_HI   19
`define SDC_FLD_TEST        20
`define SDC_FLD_SEED_OFF    21

// reset values
`define SDC_RST_STATUS      4'h0
`define SDC_RST_MASK        4'h0
`define SDC_RST_RDATA       32'h0000_0000

// divider figures of the receiver clock path
`define SDC_PRE_DIVIDE      4'h2
`define SDC_POST_DIVIDE_LO  4'h7
`define SDC_POST_DIVIDE_HI  4'h9
`define SDC_NO_DIVIDE       4'h0

`endif

// ==== verilog/strap_decode_pkg.sv ====
package strap_decode_pkg;

    // which clock feeds the internal link pll
    typedef enum logic [1:0] {
        SRC_REFERENCE,
        SRC_RECEIVER,
        SRC_PIXEL
    } pll_source_t;

    // sequence of the system reset pin
    typedef enum logic [1:0] {
        ST_HELD,
        ST_CAPTURE,
        ST_RUN
    } run_state_t;

endpackage : strap_decode_pkg

// ==== verilog/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; the output moves only when stages two and three agree
module pin_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [63:0] RST_VALUE = 64'h0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree;

    // stage1 is read by stage2 only, never by the agreement logic
    assign agree = ~(stage2 ^ stage3);

    // chain and filtered output, per bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= RST_VALUE[WIDTH-1:0];
            stage2 <= RST_VALUE[WIDTH-1:0];
            stage3 <= RST_VALUE[WIDTH-1:0];
            level  <= RST_VALUE[WIDTH-1:0];
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= (agree & stage3) | (~agree & level);
        end
    end

endmodule : pin_sync

`default_nettype wire

// ==== verification/strap_decode_sva.sv ====
`timescale 1ns/100ps
`default_nettype none

module strap_decode_sva (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       SYSTEM_RESET_N,
    input wire logic       REFERENCE_CLOCK_IN,
    input wire logic       CLOCK_SOURCE_STRAP,
    input wire logic       DIVIDER_STRAP,
    input wire logic       SCRAMBLER_SEED_RESET_OFF,
    input wire logic       TEST_PIN,
    input wire logic       INT,
    input wire logic       LOGIC_RESET_N,
    input wire logic [1:0] PLL_SOURCE,
    input wire logic [3:0] PRE_DIVIDE,
    input wire logic [3:0] POST_DIVIDE,
    input wire logic       SEED_RESET_ENABLE,
    input wire logic       TEST_MODE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // a pin held low long enough to pass the synchroniser must hold the logic
    AST_PIN_HOLD: assert property (!SYSTEM_RESET_N [*8] |-> !LOGIC_RESET_N)
        else $error("logic runs while system reset pin is low");
    AST_SRC_REF: assert property ($rose(LOGIC_RESET_N) && !CLOCK_SOURCE_STRAP
        |=> PLL_SOURCE == 2'h0 && PRE_DIVIDE == 4'h0 && POST_DIVIDE == 4'h0)
        else $error("reference source not chosen");
    AST_SRC_ALT: assert property ($rose(LOGIC_RESET_N) && CLOCK_SOURCE_STRAP
        |=> PLL_SOURCE == ($past(REFERENCE_CLOCK_IN) ? 2'h2 : 2'h1))
        else $error("receiver or pixel source wrong");
    AST_DIV: assert property ($rose(LOGIC_RESET_N) && CLOCK_SOURCE_STRAP && !REFERENCE_CLOCK_IN
        |=> PRE_DIVIDE == 4'h2 && POST_DIVIDE == ($past(DIVIDER_STRAP) ? 4'h9 : 4'h7))
        else $error("receiver divider wrong");
    // selection must stand for the whole run, whatever the straps do later
    AST_KEEP: assert property (LOGIC_RESET_N && $past(LOGIC_RESET_N) && $past(LOGIC_RESET_N, 2)
        |-> $stable(PLL_SOURCE) && $stable(POST_DIVIDE) && $stable(PRE_DIVIDE))
        else $error("clock selection moved during run");
    AST_SEED: assert property ((LOGIC_RESET_N && $stable(SCRAMBLER_SEED_RESET_OFF)) [*8]
        |-> SEED_RESET_ENABLE == !SCRAMBLER_SEED_RESET_OFF)
        else $error("seed reset enable wrong");
    AST_TEST: assert property ((LOGIC_RESET_N && $stable(TEST_PIN)) [*8]
        |-> TEST_MODE == TEST_PIN)
        else $error("test mode wrong");
    AST_INT_HELD: assert property (!LOGIC_RESET_N [*3] |-> !INT)
        else $error("interrupt high while logic held");

    // main scenarios
    COV_DIV9: cover property ($rose(LOGIC_RESET_N) && CLOCK_SOURCE_STRAP && DIVIDER_STRAP);
    COV_INT: cover property ($rose(INT));
    COV_TEST: cover property ($rose(TEST_MODE));
endmodule : strap_decode_sva

bind strap_decode_clock_select strap_decode_sva u_sva (
    .CLK(CLK), .RSTN(RSTN), .SYSTEM_RESET_N(SYSTEM_RESET_N),
    .REFERENCE_CLOCK_IN(REFERENCE_CLOCK_IN), .CLOCK_SOURCE_STRAP(CLOCK_SOURCE_STRAP),
    .DIVIDER_STRAP(DIVIDER_STRAP), .SCRAMBLER_SEED_RESET_OFF(SCRAMBLER_SEED_RESET_OFF),
    .TEST_PIN(TEST_PIN), .INT(INT), .LOGIC_RESET_N(LOGIC_RESET_N), .PLL_SOURCE(PLL_SOURCE),
    .PRE_DIVIDE(PRE_DIVIDE), .POST_DIVIDE(POST_DIVIDE),
    .SEED_RESET_ENABLE(SEED_RESET_ENABLE), .TEST_MODE(TEST_MODE));

`default_nettype wire

// ==== verification/strap_host.sv ====
`timescale 1ns/100ps
`default_nettype none

module strap_host (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic       allow_move,
    input  wire logic [2:0] want,
    output logic            sys_reset_n,
    output logic            source,
    output logic            ref_level,
    output logic            divider
);
    // reference held as a steady level; the oscillator frequency is not modelled
    // quiet pins at time zero, device held
    initial begin
        sys_reset_n = 1'b0;
        {source, ref_level, divider} = 3'h0;
    end

    // straps settle first
    // release waits one cycle after the straps match; once released the pin stays
    // high until run drops, so a strap move in run never pulses the reset pin
    always @(posedge clk) begin
        if (!sys_reset_n || allow_move) begin
            {source, ref_level, divider} <= want;
        end
        sys_reset_n <= run && (sys_reset_n || ({source, ref_level, divider} == want));
    end
endmodule : strap_host

`default_nettype wire

// ==== verification/tb_strap_decode_clock_select.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "strap_decode_consts.svh"

module tb_strap_decode_clock_select;
    logic        clk        = 1'b0;
    logic        rstn       = 1'b0;
    logic        run        = 1'b0;
    logic        allow_move = 1'b0;
    logic [2:0]  want       = 3'h0;
    logic        test_pin   = 1'b0;
    logic        seed_off   = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [31:0] wdata      = 32'h0000_0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        sys_n, src, ref_l, div, irq, lrst_n, seed_en, test_mode;
    logic [1:0]  pll_src;
    logic [3:0]  pre, post;
    logic [31:0] rdata, d;
    logic [2:0]  cfg [6] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7, 3'h5};
    int          n_errors = 0;
    int          n_tests  = 0;
    int          cycles   = 0;

    always #25 clk = ~clk;

    strap_host u_host (.clk(clk), .run(run), .allow_move(allow_move), .want(want),
        .sys_reset_n(sys_n), .source(src), .ref_level(ref_l), .divider(div));

    strap_decode_clock_select u_dut (.CLK(clk), .RSTN(rstn), .SYSTEM_RESET_N(sys_n),
        .REFERENCE_CLOCK_IN(ref_l), .CLOCK_SOURCE_STRAP(src), .DIVIDER_STRAP(div),
        .SCRAMBLER_SEED_RESET_OFF(seed_off), .TEST_PIN(test_pin), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .INT(irq), .LOGIC_RESET_N(lrst_n),
        .PLL_SOURCE(pll_src), .PRE_DIVIDE(pre), .POST_DIVIDE(post),
        .SEED_RESET_ENABLE(seed_en), .TEST_MODE(test_mode));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // one-cycle strobes; read data stand only in the cycle after the strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // s is {source strap, reference level, divider strap}
    task automatic boot(input logic [2:0] s);
        logic [1:0] es;
        logic [3:0] ep, eq;
        es = !s[2] ? 2'h0 : (s[1] ? 2'h2 : 2'h1);
        ep = (es == 2'h1) ? `SDC_PRE_DIVIDE : `SDC_NO_DIVIDE;
        eq = (es != 2'h1) ? `SDC_NO_DIVIDE : (s[0] ? `SDC_POST_DIVIDE_HI : `SDC_POST_DIVIDE_LO);
        @(posedge clk);
        run <= 1'b0;
        want <= s;
        tick(12);
        check(lrst_n, 1'b0);
        check(irq, 1'b0);
        @(posedge clk);
        run <= 1'b1;
        for (int i = 0; i < 30 && lrst_n !== 1'b1; i++) tick(1);
        tick(2);
        check(lrst_n, 1'b1);
        check(pll_src == 2'h0, !s[2]);
        check(pll_src, es);
        check(pre, ep);
        check(post, eq);
        rd_reg(`SDC_OFS_MASK);
        check(d, 32'h0000_0000);
        $display("boot %h done", s);
    endtask : boot

    task automatic irq_test;
        rd_reg(`SDC_OFS_STATUS);
        check(d, 32'h0000_0001);
        wr_reg(`SDC_OFS_MASK, 32'h0000_000F);
        tick(2);
        check(irq, 1'b1);
        wr_reg(`SDC_OFS_STATUS, 32'h0000_0001);
        tick(2);
        check(irq, 1'b0);
        wr_reg(`SDC_OFS_CONTROL, 32'h0000_0001);
        tick(2);
        check(irq, 1'b1);
        wr_reg(`SDC_OFS_MASK, 32'h0000_0007);
        tick(2);
        check(irq, 1'b0);
        rd_reg(`SDC_OFS_STATUS);
        check(d, 32'h0000_0008);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_reg(8'h20);
        check(d, 32'h0000_0000);
        rd_reg(`SDC_OFS_MASK);
        check(d, 32'h0000_0007);
        rd_reg(`SDC_OFS_CAPTURE);
        check(d & 32'h000F_FFFF, 32'h0006_0921);
        $display("interrupt test done");
    endtask : irq_test

    task automatic move_test;
        @(posedge clk);
        allow_move <= 1'b1;
        want <= 3'h6;
        tick(10);
        check(pll_src, 2'h1);
        check(post, `SDC_POST_DIVIDE_HI);
        rd_reg(`SDC_OFS_STATUS);
        check(d[1], 1'b1);
        check(lrst_n, 1'b1);
        rd_reg(`SDC_OFS_PINS);
        check(d, 32'h0003_0002);
        allow_move <= 1'b0;
        $display("strap move test done");
    endtask : move_test

    task automatic pin_test;
        @(posedge clk);
        test_pin <= 1'b1;
        seed_off <= 1'b1;
        tick(9);
        check(test_mode, 1'b1);
        check(seed_en, 1'b0);
        rd_reg(`SDC_OFS_STATUS);
        check(d[2], 1'b1);
        check(irq, 1'b1);
        @(posedge clk);
        test_pin <= 1'b0;
        seed_off <= 1'b0;
        tick(9);
        check(test_mode, 1'b0);
        check(seed_en, 1'b1);
        $display("pin test done");
    endtask : pin_test

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // hang guard, the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            $display("ERROR %0t timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (cfg[i]) boot(cfg[i]);
        irq_test();
        move_test();
        pin_test();
        boot(3'h0);
        report_and_stop();
    end
endmodule : tb_strap_decode_clock_select

`default_nettype wire
